// ===== rtl/bus_pin_float_control.sv
// Output-enable and pin-mode control for the external bus interface.
// Assumes bus-side inputs are synchronous to clk; mode straps are not and
// pass the synchroniser. Output enables are active low (low = driving).
`timescale 1ns/1ps
module bus_pin_float_control (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tristate_test_in,
  input wire logic checker_mode_in,
  input wire logic dual_cfg_in,
  input wire logic addr_bit20_mask_in_n,
  input wire logic ignore_numeric_error_in_n,
  input wire logic dual_mode_in,
  input wire logic pb_owner_in,
  input wire logic bus_hold_in,
  input wire logic addr_hold_in,
  input wire logic bus_backoff_in_n,
  input wire logic burst_ready_in_n,
  input wire logic burst_ready_copy_in_n,
  input wire pin_float_pkg::bus_state_t bus_state_in,
  input wire pin_float_pkg::tap_state_t tap_state_in,
  input wire logic tdo_core_in,
  input wire logic [pin_float_pkg::ADDR_W-1:0] core_addr,
  input wire logic core_addr_parity,
  input wire logic [pin_float_pkg::LOW_BE_W-1:0] core_low_be_n,
  input wire logic [pin_float_pkg::HIGH_BE_W-1:0] core_high_be_n,
  input wire logic [pin_float_pkg::DATA_W-1:0] core_data,
  input wire logic [pin_float_pkg::DPAR_W-1:0] core_data_parity,
  input wire logic [pin_float_pkg::SHARED_W-1:0] core_shared,
  input wire logic core_addr_strobe_copy_n,
  input wire logic [1:0] core_page_attr,
  input wire logic core_internal_error_out_n,
  input wire logic core_fpu_error_out_n,
  input wire logic core_dual_role,
  input wire logic [pin_float_pkg::ADDR_W-1:0] addr_lines_in,
  input wire logic [pin_float_pkg::DATA_W-1:0] data_lines_in,
  input wire logic [pin_float_pkg::SHARED_W-1:0] shared_pins_in,
  output logic [pin_float_pkg::ADDR_W-1:0] addr_lines_out,
  output logic addr_parity_out,
  output logic [pin_float_pkg::LOW_BE_W-1:0] low_byte_lane_enables_n,
  output logic addr_group_oe_n,
  output logic [pin_float_pkg::HIGH_BE_W-1:0] high_byte_lane_enables_n,
  output logic addr_strobe_out_n,
  output logic addr_strobe_copy_out_n,
  output logic [pin_float_pkg::CYC_W-1:0] cycle_def_out,
  output logic line_fill_out_n,
  output logic bus_lock_out_n,
  output logic split_cycle_out,
  output logic snoop_modified_match_out_n,
  output logic hold_ack_out,
  output logic shared_oe_n,
  output logic ctl_oe_n,
  output logic page_write_thru_out,
  output logic page_no_cache_out,
  output logic [pin_float_pkg::DATA_W-1:0] data_lines_out,
  output logic [pin_float_pkg::DPAR_W-1:0] data_parity_lines_out,
  output logic data_oe_n,
  output logic internal_error_out_n,
  output logic internal_error_out_oe_n,
  output logic fpu_error_out_n,
  output logic dual_role_out,
  output logic dp_misc_oe_n,
  output logic tdo_out,
  output logic tdo_oe_n,
  output logic burst_ready_valid,
  output logic [pin_float_pkg::DATA_W-1:0] data_rx,
  output logic [pin_float_pkg::ADDR_W-1:0] snoop_addr_rx,
  output logic [pin_float_pkg::SHARED_W-1:0] shared_rx,
  output logic addr_bit20_mask_eff,
  output logic ignore_numeric_error_eff
);

  mode_sync_if msync ();

  // ----------------------------------------------------------------------
  // Mode synchronisation
  // ----------------------------------------------------------------------
  // Test and strap pins are asynchronous; masks are active low at the pin
  mode_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .raw({~ignore_numeric_error_in_n, ~addr_bit20_mask_in_n, dual_cfg_in,
          checker_mode_in, tristate_test_in}),
    .sync(msync.src)
  );

  logic tri_m;
  logic chk_m;
  logic dual_m;
  logic all_float;
  logic hold_bo;
  logic addr_float;
  logic ctl_float;
  logic shared_float;
  logic burst_ready_in_ok;
  logic tdo_shift;

  // ----------------------------------------------------------------------
  // Float decisions
  // ----------------------------------------------------------------------
  // Plain decode from synchronised modes and synchronous bus inputs
  assign tri_m = msync.mode[pin_float_pkg::MD_TRI];
  assign chk_m = msync.mode[pin_float_pkg::MD_CHK];
  assign dual_m = msync.mode[pin_float_pkg::MD_DUAL];
  assign all_float = tri_m | chk_m;
  assign hold_bo = bus_hold_in | ~bus_backoff_in_n;
  assign addr_float = all_float | hold_bo | addr_hold_in;
  assign ctl_float = all_float | hold_bo;
  // Shared pins yield to the partner whenever it owns the private bus
  assign shared_float = ctl_float | (dual_mode_in & ~pb_owner_in);
  assign burst_ready_in_ok = pin_float_pkg::burst_ready_in_window(bus_state_in);
  assign tdo_shift = (tap_state_in == pin_float_pkg::TAP_SHIFT_DR) ||
                     (tap_state_in == pin_float_pkg::TAP_SHIFT_IR);

  // Scan output follows the controller state directly, no bus clock delay
  assign tdo_oe_n = tdo_shift ? pin_float_pkg::OE_DRIVE : pin_float_pkg::OE_FLOAT;
  assign tdo_out = tdo_core_in;

  // Burst ready is a handshake qualifier, so it stays combinational
  assign burst_ready_valid = burst_ready_in_ok & ~(burst_ready_in_n & burst_ready_copy_in_n);

  // Inputs that are undefined as dual processor are masked off
  assign addr_bit20_mask_eff = msync.mode[pin_float_pkg::MD_A20] & ~dual_m;
  assign ignore_numeric_error_eff = msync.mode[pin_float_pkg::MD_IGN] & ~dual_m;

  // ----------------------------------------------------------------------
  // Output enables, registered so pins release cleanly one edge later
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_group_oe_n <= pin_float_pkg::OE_FLOAT;
      ctl_oe_n <= pin_float_pkg::OE_FLOAT;
      shared_oe_n <= pin_float_pkg::OE_FLOAT;
      data_oe_n <= pin_float_pkg::OE_FLOAT;
      internal_error_out_oe_n <= pin_float_pkg::OE_FLOAT;
      dp_misc_oe_n <= pin_float_pkg::OE_FLOAT;
    end else begin
      addr_group_oe_n <= addr_float;
      ctl_oe_n <= ctl_float;
      shared_oe_n <= shared_float;
      data_oe_n <= ctl_float;
      internal_error_out_oe_n <= tri_m;
      dp_misc_oe_n <= all_float | dual_m;
    end
  end

  // ----------------------------------------------------------------------
  // Pin data registers
  // ----------------------------------------------------------------------
  // Outgoing values are flopped so pin timing never sees core glitches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_lines_out <= '0;
      addr_parity_out <= pin_float_pkg::FLAG_RST;
      low_byte_lane_enables_n <= '1;
      high_byte_lane_enables_n <= '1;
      addr_strobe_copy_out_n <= pin_float_pkg::STRB_IDLE;
      page_write_thru_out <= pin_float_pkg::FLAG_RST;
      page_no_cache_out <= pin_float_pkg::FLAG_RST;
      data_lines_out <= pin_float_pkg::DATA_RST;
      data_parity_lines_out <= '0;
      internal_error_out_n <= pin_float_pkg::STRB_IDLE;
      fpu_error_out_n <= pin_float_pkg::STRB_IDLE;
      dual_role_out <= pin_float_pkg::FLAG_RST;
    end else begin
      addr_lines_out <= core_addr;
      addr_parity_out <= core_addr_parity;
      low_byte_lane_enables_n <= core_low_be_n;
      high_byte_lane_enables_n <= core_high_be_n;
      addr_strobe_copy_out_n <= core_addr_strobe_copy_n;
      page_write_thru_out <= core_page_attr[0];
      page_no_cache_out <= core_page_attr[1];
      data_lines_out <= core_data;
      data_parity_lines_out <= core_data_parity;
      internal_error_out_n <= core_internal_error_out_n;
      fpu_error_out_n <= core_fpu_error_out_n;
      dual_role_out <= core_dual_role;
    end
  end

  logic [pin_float_pkg::SHARED_W-1:0] shared_out_r;

  // Shared dual-processing pins, split out to their own ports
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shared_out_r <= 9'h17F;
    end else begin
      shared_out_r <= core_shared;
    end
  end

  assign addr_strobe_out_n = shared_out_r[pin_float_pkg::SH_ADS];
  assign cycle_def_out = shared_out_r[pin_float_pkg::SH_CYC_HI:pin_float_pkg::SH_CYC_LO];
  assign line_fill_out_n = shared_out_r[pin_float_pkg::SH_CACHE];
  assign bus_lock_out_n = shared_out_r[pin_float_pkg::SH_LOCK];
  assign split_cycle_out = shared_out_r[pin_float_pkg::SH_SPLIT_CYCLE_OUT];
  assign snoop_modified_match_out_n = shared_out_r[pin_float_pkg::SH_SNOOP_MODIFIED_MATCH_OUT];
  assign hold_ack_out = shared_out_r[pin_float_pkg::SH_HOLD_ACK_OUT];

  // ----------------------------------------------------------------------
  // Inbound capture
  // ----------------------------------------------------------------------
  // Read data is only trusted on a qualified burst ready
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_rx <= pin_float_pkg::DATA_RST;
      snoop_addr_rx <= '0;
      shared_rx <= '1;
    end else begin
      if (burst_ready_valid) begin
        data_rx <= data_lines_in;
      end
      if (addr_hold_in) begin
        snoop_addr_rx <= addr_lines_in;
      end
      // Partner's view is only meaningful while we are not driving
      if (dual_mode_in && !pb_owner_in) begin
        shared_rx <= shared_pins_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  tri_floats_a: assert property (tri_m |=> (data_oe_n && internal_error_out_oe_n && addr_group_oe_n))
    else $error("pins driven in tristate test");
  chk_keeps_a: assert property (chk_m && !tri_m |=> (!internal_error_out_oe_n && ctl_oe_n && shared_oe_n))
    else $error("checker float set wrong");
  tdo_shift_a: assert property (tdo_oe_n ^ (tap_state_in inside
    {pin_float_pkg::TAP_SHIFT_DR, pin_float_pkg::TAP_SHIFT_IR}))
    else $error("scan output enable mismatch");
  tdo_tri_a: assert property (tri_m && tdo_shift |-> !tdo_oe_n)
    else $error("scan output floated in tristate test");
  addr_hold_a: assert property (addr_hold_in && !all_float |=> addr_group_oe_n)
    else $error("address driven during address hold");
  addr_back_a: assert property ($fell(bus_backoff_in_n) |=> addr_group_oe_n && data_oe_n)
    else $error("address driven during backoff");
  burst_ready_in_qual_a: assert property (!(bus_state_in inside {pin_float_pkg::BUS_T2,
    pin_float_pkg::BUS_T12, pin_float_pkg::BUS_T2P}) |-> !burst_ready_valid)
    else $error("burst ready outside window");
  burst_ready_in_take_a: assert property (burst_ready_valid |=> data_rx == $past(data_lines_in))
    else $error("read data not captured");
  shared_yield_a: assert property (dual_mode_in && !pb_owner_in |=> shared_oe_n)
    else $error("shared pins driven by non-owner");
  dual_misc_a: assert property (dual_m |=> dp_misc_oe_n)
    else $error("dual role outputs driven");
  dual_mask_a: assert property (dual_m |-> !addr_bit20_mask_eff && !ignore_numeric_error_eff)
    else $error("undefined inputs honoured");
  hold_ctl_a: assert property (bus_hold_in ##1 bus_hold_in |-> ctl_oe_n && data_oe_n)
    else $error("controls driven in bus hold");

  burst_seen_c: cover property (burst_ready_in_ok ##1 burst_ready_valid);
  hold_release_c: cover property (ctl_oe_n ##1 !ctl_oe_n);
  scan_shift_c: cover property (tdo_oe_n ##1 !tdo_oe_n);
  dual_yield_c: cover property (!shared_oe_n ##1 shared_oe_n);

endmodule : bus_pin_float_control

// ===== rtl/pin_float_pkg.sv
// Shared constants and types for the external bus pin float control.
// Assumes a single 20 MHz bus clock; scan controller state arrives encoded
// as tap_state_t from logic on that same clock.
package pin_float_pkg;

  // ----------------------------------------------------------------------
  // Pin group widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 29;
  localparam int LOW_BE_W = 5;
  localparam int HIGH_BE_W = 3;
  localparam int DATA_W = 64;
  localparam int DPAR_W = 8;
  localparam int CYC_W = 3;
  localparam int SHARED_W = 9;

  // ----------------------------------------------------------------------
  // Field positions inside the shared dual-processing pin vector
  // ----------------------------------------------------------------------
  localparam int SH_ADS = 0;
  localparam int SH_CYC_LO = 1;
  localparam int SH_CYC_HI = 3;
  localparam int SH_CACHE = 4;
  localparam int SH_LOCK = 5;
  localparam int SH_SPLIT_CYCLE_OUT = 6;
  localparam int SH_SNOOP_MODIFIED_MATCH_OUT = 7;
  localparam int SH_HOLD_ACK_OUT = 8;

  // ----------------------------------------------------------------------
  // Values after reset and synchroniser length
  // ----------------------------------------------------------------------
  localparam logic OE_FLOAT = 1'b1;
  localparam logic OE_DRIVE = 1'b0;
  localparam logic STRB_IDLE = 1'b1;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [63:0] DATA_RST = 64'h0000_0000_0000_0000;
  localparam int SYNC_STAGES = 3;
  localparam int MODE_W = 5;

  // Mode bit positions inside the synchronised mode vector
  localparam int MD_TRI = 0;
  localparam int MD_CHK = 1;
  localparam int MD_DUAL = 2;
  localparam int MD_A20 = 3;
  localparam int MD_IGN = 4;

  // Boundary-scan controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  // Bus cycle state machine states
  typedef enum logic [2:0] {
    BUS_TI, BUS_T1, BUS_T2, BUS_T12, BUS_T2P, BUS_TD
  } bus_state_t;

  // Burst-ready sampling window
  function automatic logic burst_ready_in_window(input bus_state_t s);
    return (s == BUS_T2) || (s == BUS_T12) || (s == BUS_T2P);
  endfunction : burst_ready_in_window

endpackage : pin_float_pkg

// ===== rtl/mode_sync_if.sv
// Carries synchronised mode levels from the synchroniser to the control.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
interface mode_sync_if;
  logic [pin_float_pkg::MODE_W-1:0] mode;
  modport src (output mode);
  modport dst (input mode);
endinterface : mode_sync_if

// ===== rtl/mode_sync.sv
// Three-stage synchroniser for asynchronous mode and strap inputs.
// Assumes inputs are slow levels; a change is taken once stages two and
// three agree, so a single-cycle glitch never reaches the control logic.
`timescale 1ns/1ps
module mode_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [pin_float_pkg::MODE_W-1:0] raw,
  mode_sync_if.src sync
);

  logic [pin_float_pkg::MODE_W-1:0] s1_r;
  logic [pin_float_pkg::MODE_W-1:0] s2_r;
  logic [pin_float_pkg::MODE_W-1:0] s3_r;
  logic [pin_float_pkg::MODE_W-1:0] out_r;
  logic [pin_float_pkg::MODE_W-1:0] out_nxt;

  // ----------------------------------------------------------------------
  // Agreement filter
  // ----------------------------------------------------------------------
  // Per bit, take stage two only when stage three confirms it
  assign out_nxt = (s2_r & ~(s2_r ^ s3_r)) | (out_r & (s2_r ^ s3_r));

  // Stage chain; s1_r is read by s2_r alone
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync.mode = out_r;

endmodule : mode_sync

// ===== dv/chipset_model.sv
// Far-side chipset model: bus hold, backoff, burst ready and read data.
// Assumes bench requests change just after a rising clk edge.
`timescale 1ns/1ps
module chipset_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hold_req,
  input wire logic backoff_req,
  input wire logic burst_ready_in_req,
  input wire logic burst_ready_in_copy,
  input wire logic [63:0] burst_ready_in_data,
  output logic bus_hold_in,
  output logic bus_backoff_in_n,
  output logic burst_ready_in_n,
  output logic burst_ready_copy_in_n,
  output logic [63:0] data_lines_in
);
  logic [63:0] last_r;
  // Requests map straight onto pins; the copy pin idles at its pull-up level
  assign bus_hold_in = hold_req;
  assign bus_backoff_in_n = ~backoff_req;
  assign burst_ready_in_n = ~(burst_ready_in_req & ~burst_ready_in_copy);
  assign burst_ready_copy_in_n = ~(burst_ready_in_req & burst_ready_in_copy);
  // Released data flips every cycle, so a stale word can never pass as fresh
  assign data_lines_in = burst_ready_in_req ? burst_ready_in_data : ~last_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) last_r <= 64'h0;
    else last_r <= data_lines_in;
  end
endmodule : chipset_model

// ===== dv/bus_pin_float_control_tb.sv
// Self-checking bench for the bus pin float control.
// Assumes the chipset model on the bus side; modes pass a 3-flop sync.
`timescale 1ns/1ps
module bus_pin_float_control_tb;
  logic clk, nrst, tristate_test_in, checker_mode_in, dual_cfg_in, dual_mode_in;
  logic addr_bit20_mask_in_n, ignore_numeric_error_in_n, pb_owner_in, addr_hold_in;
  logic tdo_core_in, core_addr_parity, core_addr_strobe_copy_n, core_internal_error_out_n;
  logic core_fpu_error_out_n, core_dual_role, hold_req, backoff_req, burst_ready_in_req, burst_ready_in_copy;
  logic bus_hold_in, bus_backoff_in_n, burst_ready_in_n, burst_ready_copy_in_n;
  pin_float_pkg::bus_state_t bus_state_in;
  pin_float_pkg::tap_state_t tap_state_in;
  logic [28:0] core_addr, addr_lines_in, snoop_addr_rx;
  logic [4:0] core_low_be_n;
  logic [2:0] core_high_be_n;
  logic [63:0] core_data, burst_ready_in_data, data_lines_in, data_rx;
  logic [7:0] core_data_parity;
  logic [8:0] core_shared, shared_pins_in, shared_rx;
  logic [1:0] core_page_attr;
  logic addr_group_oe_n, ctl_oe_n, shared_oe_n, data_oe_n, internal_error_out_oe_n, dp_misc_oe_n;
  logic tdo_out, tdo_oe_n, burst_ready_valid, addr_bit20_mask_eff, ignore_numeric_error_eff;
  logic [5:0] oe_all;
  logic [28:0] addr_lines_out;
  logic [63:0] data_lines_out;
  logic [7:0] data_parity_lines_out, be_out;
  logic [4:0] low_byte_lane_enables_n;
  logic [2:0] high_byte_lane_enables_n, cycle_def_out;
  logic addr_parity_out, addr_strobe_out_n, addr_strobe_copy_out_n, line_fill_out_n;
  logic bus_lock_out_n, split_cycle_out, snoop_modified_match_out_n, hold_ack_out;
  logic page_write_thru_out, page_no_cache_out, internal_error_out_n, fpu_error_out_n;
  logic dual_role_out;
  logic [8:0] shared_out;
  logic [6:0] misc_out;
  // Pin groups packed in core bit order so one compare covers each group
  assign be_out = {high_byte_lane_enables_n, low_byte_lane_enables_n};
  assign shared_out = {hold_ack_out, snoop_modified_match_out_n, split_cycle_out,
    bus_lock_out_n, line_fill_out_n, cycle_def_out, addr_strobe_out_n};
  assign misc_out = {addr_parity_out, addr_strobe_copy_out_n, page_no_cache_out,
    page_write_thru_out, internal_error_out_n, fpu_error_out_n, dual_role_out};
  int mismatches, comparisons, cycles;
  assign oe_all = {addr_group_oe_n, ctl_oe_n, shared_oe_n, data_oe_n, internal_error_out_oe_n, dp_misc_oe_n};

  bus_pin_float_control u_dut (.clk, .nrst, .tristate_test_in, .checker_mode_in,
    .dual_cfg_in, .addr_bit20_mask_in_n, .ignore_numeric_error_in_n, .dual_mode_in,
    .pb_owner_in, .bus_hold_in, .addr_hold_in, .bus_backoff_in_n, .burst_ready_in_n,
    .burst_ready_copy_in_n, .bus_state_in, .tap_state_in, .tdo_core_in, .core_addr,
    .core_addr_parity, .core_low_be_n, .core_high_be_n, .core_data, .core_data_parity,
    .core_shared, .core_addr_strobe_copy_n, .core_page_attr, .core_internal_error_out_n, .core_fpu_error_out_n,
    .core_dual_role, .addr_lines_in, .data_lines_in, .shared_pins_in, .addr_lines_out,
    .addr_parity_out, .low_byte_lane_enables_n, .addr_group_oe_n,
    .high_byte_lane_enables_n, .addr_strobe_out_n, .addr_strobe_copy_out_n,
    .cycle_def_out, .line_fill_out_n, .bus_lock_out_n, .split_cycle_out,
    .snoop_modified_match_out_n, .hold_ack_out, .shared_oe_n, .ctl_oe_n,
    .page_write_thru_out, .page_no_cache_out, .data_lines_out,
    .data_parity_lines_out, .data_oe_n, .internal_error_out_n, .internal_error_out_oe_n,
    .fpu_error_out_n, .dual_role_out, .dp_misc_oe_n, .tdo_out, .tdo_oe_n,
    .burst_ready_valid, .data_rx, .snoop_addr_rx, .shared_rx, .addr_bit20_mask_eff,
    .ignore_numeric_error_eff);

  chipset_model u_chipset (.clk, .nrst, .hold_req, .backoff_req, .burst_ready_in_req, .burst_ready_in_copy,
    .burst_ready_in_data, .bus_hold_in, .bus_backoff_in_n, .burst_ready_in_n,
    .burst_ready_copy_in_n, .data_lines_in);

  // ----------------------------------------------------------------------
  // Clock, watchdog and shared helpers
  // ----------------------------------------------------------------------
  always #25 clk = ~clk;

  // Whole run is under a hundred cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // One edge for the design to sample, then look once outputs have settled
  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask : step

  // Mode straps cross a synchroniser, so poll under a bounded count
  task automatic wait_oe(input logic [5:0] exp);
    int n;
    n = 0;
    while (oe_all !== exp && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk("oe_all", {58'h0, exp}, {58'h0, oe_all});
  endtask : wait_oe

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Hold, backoff, address hold: exactly one edge to float, one to recover
  task automatic t_bus_float();
    @(posedge clk);
    backoff_req <= 1'b1;
    @(negedge clk);
    chk("oe_early", 64'h0, {58'h0, oe_all});
    step();
    chk("oe_backoff", 64'h3C, {58'h0, oe_all});
    @(posedge clk);
    backoff_req <= 1'b0;
    hold_req <= 1'b1;
    step();
    chk("oe_hold", 64'h3C, {58'h0, oe_all});
    @(posedge clk);
    hold_req <= 1'b0;
    addr_hold_in <= 1'b1;
    step();
    chk("oe_ahold", 64'h20, {58'h0, oe_all});
    step();
    chk("snoop_addr", {35'h0, addr_lines_in}, {35'h0, snoop_addr_rx});
    @(posedge clk);
    addr_hold_in <= 1'b0;
    step();
    chk("oe_idle", 64'h0, {58'h0, oe_all});
  endtask : t_bus_float

  // Pin values launch one edge after the core presents them
  task automatic t_pin_data();
    @(posedge clk);
    core_addr <= 29'h1555_AAAA;
    core_data <= 64'h0123_4567_89AB_CDEF;
    core_data_parity <= 8'h3C;
    core_low_be_n <= 5'h05;
    core_high_be_n <= 3'h2;
    core_shared <= 9'h0C6;
    {core_addr_parity, core_addr_strobe_copy_n, core_page_attr} <= 4'h1;
    {core_internal_error_out_n, core_fpu_error_out_n, core_dual_role} <= 3'h1;
    @(negedge clk);
    chk("addr_early", {35'h0, 29'h0ABC_DEF1}, {35'h0, addr_lines_out});
    step();
    chk("addr_out", {35'h0, 29'h1555_AAAA}, {35'h0, addr_lines_out});
    chk("be_out", 64'h45, {56'h0, be_out});
    chk("data_out", 64'h0123_4567_89AB_CDEF, data_lines_out);
    chk("dpar_out", 64'h3C, {56'h0, data_parity_lines_out});
    chk("shared_out", 64'h0C6, {55'h0, shared_out});
    chk("misc_out", 64'h09, {57'h0, misc_out});
  endtask : t_pin_data

  // Tristate test floats all but the scan output; checker keeps the error pin and scan output driven
  task automatic t_modes();
    @(posedge clk);
    tap_state_in <= pin_float_pkg::TAP_SHIFT_DR;
    tristate_test_in <= 1'b1;
    wait_oe(6'h3F);
    chk("tdo_oe_tri", 64'h0, {63'h0, tdo_oe_n});
    @(posedge clk);
    tristate_test_in <= 1'b0;
    checker_mode_in <= 1'b1;
    wait_oe(6'h3D);
    chk("tdo_oe_chk", 64'h0, {63'h0, tdo_oe_n});
    @(posedge clk);
    checker_mode_in <= 1'b0;
    wait_oe(6'h00);
  endtask : t_modes

  // Scan output drives only in the two shift states, in every state
  task automatic t_scan_out();
    logic shift;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      tap_state_in <= pin_float_pkg::tap_state_t'(i);
      tdo_core_in <= i[0];
      @(negedge clk);
      shift = (i == 4) || (i == 11);
      chk("tdo_oe_n", {63'h0, ~shift}, {63'h0, tdo_oe_n});
      if (shift) chk("tdo_out", {63'h0, i[0]}, {63'h0, tdo_out});
    end
  endtask : t_scan_out

  // Burst ready counts only in the three data states, via either copy
  task automatic t_burst_ready();
    logic ok;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      bus_state_in <= pin_float_pkg::bus_state_t'(i % 6);
      burst_ready_in_req <= 1'b1;
      burst_ready_in_copy <= i[0];
      burst_ready_in_data <= 64'hC3C3_0000_0000_0000 + 64'(i);
      @(negedge clk);
      ok = (i % 6 == 2) || (i % 6 == 3) || (i % 6 == 4);
      chk("burst_ready_in_valid", {63'h0, ok}, {63'h0, burst_ready_valid});
      @(posedge clk);
      burst_ready_in_req <= 1'b0;
      @(negedge clk);
      chk("burst_ready_in_idle", 64'h0, {63'h0, burst_ready_valid});
      if (ok) chk("data_rx", 64'hC3C3_0000_0000_0000 + 64'(i), data_rx);
    end
  endtask : t_burst_ready

  // Non-owner in dual mode floats shared pins and listens to the partner
  task automatic t_dual_mode();
    @(posedge clk);
    dual_mode_in <= 1'b1;
    pb_owner_in <= 1'b0;
    step();
    chk("oe_dual", 64'h08, {58'h0, oe_all});
    step();
    chk("shared_rx", {55'h0, shared_pins_in}, {55'h0, shared_rx});
    @(posedge clk);
    pb_owner_in <= 1'b1;
    step();
    chk("oe_owner", 64'h0, {58'h0, oe_all});
    @(posedge clk);
    dual_mode_in <= 1'b0;
  endtask : t_dual_mode

  // Dual-processor strap: role/fpu pins undefined, mask/ignore inputs void
  task automatic t_dual_cfg();
    @(posedge clk);
    addr_bit20_mask_in_n <= 1'b0;
    ignore_numeric_error_in_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("mask_eff", 64'h1, {63'h0, addr_bit20_mask_eff});
    chk("ign_eff", 64'h1, {63'h0, ignore_numeric_error_eff});
    dual_cfg_in <= 1'b1;
    wait_oe(6'h01);
    chk("mask_eff_dp", 64'h0, {63'h0, addr_bit20_mask_eff});
    chk("ign_eff_dp", 64'h0, {63'h0, ignore_numeric_error_eff});
  endtask : t_dual_cfg

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {clk, nrst, tristate_test_in, checker_mode_in, dual_cfg_in, dual_mode_in} = '0;
    {addr_bit20_mask_in_n, ignore_numeric_error_in_n, pb_owner_in} = 3'b111;
    {addr_hold_in, tdo_core_in, hold_req, backoff_req, burst_ready_in_req, burst_ready_in_copy} = '0;
    {core_addr_parity, core_addr_strobe_copy_n, core_internal_error_out_n, core_fpu_error_out_n} = 4'h7;
    core_dual_role = 1'b0;
    bus_state_in = pin_float_pkg::BUS_TI;
    tap_state_in = pin_float_pkg::TAP_IDLE;
    core_addr = 29'h0ABC_DEF1;
    addr_lines_in = 29'h1234_5678;
    core_low_be_n = 5'h1A;
    core_high_be_n = 3'h5;
    core_data = 64'hA5A5_5A5A_0F0F_F0F0;
    burst_ready_in_data = 64'h0;
    core_data_parity = 8'h96;
    core_shared = 9'h17F;
    shared_pins_in = 9'h0A5;
    core_page_attr = 2'h2;
    {mismatches, comparisons, cycles} = '0;
    repeat (3) @(posedge clk);
    chk("oe_reset", 64'h3F, {58'h0, oe_all});
    nrst <= 1'b1;
    wait_oe(6'h00);
    t_bus_float();
    t_pin_data();
    t_modes();
    t_scan_out();
    t_burst_ready();
    t_dual_mode();
    t_dual_cfg();
    print_verdict();
  end
endmodule : bus_pin_float_control_tb
